// [common/err_slave_defs.vh]
// constants shared by the default error slave and its violation log
`ifndef ERR_SLAVE_DEFS_VH
`define ERR_SLAVE_DEFS_VH

// axi side widths
`define AXI_ID_W       4
`define AXI_ADDR_W     32
`define AXI_DATA_W     32
`define AXI_LEN_W      8
`define AXI_ZERO_LEN   8'h00
`define AXI_ONE_LEN    8'h01
`define AXI_RESP_DECERR 2'h3
`define AXI_DATA_ZERO  32'h0000_0000

// violation log: one entry is {id, addr}
`define LOG_ENTRY_W    36
`define LOG_PTR_W      2
`define LOG_CNT_W      3
`define LOG_FULL_CNT   3'h4
`define LOG_LAST_PTR   2'h3
`define LOG_PTR_ZERO   2'h0
`define LOG_PTR_ONE    2'h1
`define LOG_CNT_ZERO   3'h0
`define LOG_CNT_ONE    3'h1

// apb register map, byte addresses
`define APB_ADDR_W     8
`define CSR_STATUS     8'h00
`define CSR_MASK       8'h04
`define CSR_RLOG_INFO  8'h10
`define CSR_RLOG_ADDR  8'h14
`define CSR_WLOG_INFO  8'h20
`define CSR_WLOG_ADDR  8'h24

// status and mask field layout
`define ST_W           4
`define ST_RD_INT      0
`define ST_WR_INT      1
`define ST_WR_OVF      2
`define ST_RD_OVF      3
`define ST_ZERO        4'h0
`define LOG_VALID_BIT  31
`define REG_ZERO       32'h0000_0000

`endif

// [src/axi_default_error_slave.v]
// axi default slave answering every access with decerr, apb log port
// Overview of operation
// - accept every transaction, answer with decerr
// - one outstanding read and one write
// - read and write channels run independently
// - log id and address when responding
// - plain axi3/axi4 slave ports, no bridge
// - separate read and write violation status
// - overflow bits on full log, w1c
// - violation log is a fifo
// - interrupt clears once logs drained and overflow bits cleared
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`include "err_slave_defs.vh"

module axi_default_error_slave
(
	input  wire                   sys_clk,
	input  wire                   rst_b,
	input  wire [`AXI_ID_W-1:0]   awid,
	input  wire [`AXI_ADDR_W-1:0] awaddr,
	input  wire [`AXI_LEN_W-1:0]  awlen,
	input  wire [2:0]             awsize,
	input  wire [1:0]             awburst,
	input  wire                   awvalid,
	output reg                    awready,
	input  wire [`AXI_DATA_W-1:0] wdata,
	input  wire [3:0]             wstrb,
	input  wire                   wlast,
	input  wire                   wvalid,
	output reg                    wready,
	output reg  [`AXI_ID_W-1:0]   bid,
	output reg  [1:0]             bresp,
	output reg                    bvalid,
	input  wire                   bready,
	input  wire [`AXI_ID_W-1:0]   arid,
	input  wire [`AXI_ADDR_W-1:0] araddr,
	input  wire [`AXI_LEN_W-1:0]  arlen,
	input  wire [2:0]             arsize,
	input  wire [1:0]             arburst,
	input  wire                   arvalid,
	output reg                    arready,
	output reg  [`AXI_ID_W-1:0]   rid,
	output reg  [`AXI_DATA_W-1:0] rdata,
	output reg  [1:0]             rresp,
	output reg                    rlast,
	output reg                    rvalid,
	input  wire                   rready,
	input  wire                   psel,
	input  wire                   penable,
	input  wire                   pwrite,
	input  wire [`APB_ADDR_W-1:0] paddr,
	input  wire [31:0]            pwdata,
	output reg  [31:0]            prdata,
	output reg                    pready,
	output reg                    pslverr,
	output reg                    irq
);

	localparam [1:0] W_IDLE = 2'b00;
	localparam [1:0] W_DATA = 2'b01;
	localparam [1:0] W_RESP = 2'b10;
	localparam [1:0] R_IDLE = 2'b00;
	localparam [1:0] R_DATA = 2'b01;
	reg  [1:0]              wState;
	reg  [1:0]              rState;
	reg  [`AXI_ADDR_W-1:0]  wAddr;
	reg  [`AXI_ADDR_W-1:0]  rAddr;
	reg  [`AXI_LEN_W-1:0]   beatsLeft;
	reg  [`ST_W-1:0]        status;
	reg  [`ST_W-1:0]        mask;
	reg  [`ST_W-1:0]        next_status;
	reg  [31:0]             next_prdata;
	reg                     next_slverr;
	wire                    wDone;
	wire                    rDone;
	wire                    apbWrite;
	wire                    apbRead;
	wire                    rLogPop;
	wire                    wLogPop;
	wire [`LOG_ENTRY_W-1:0] rLogHead;
	wire [`LOG_ENTRY_W-1:0] wLogHead;
	wire                    rLogValid;
	wire                    wLogValid;
	wire                    rLogFull;
	wire                    wLogFull;
	// response handshakes are the moments of logging
	assign wDone = bvalid & bready;
	assign rDone = rvalid & rready & rlast;
	// write channel: address, all data beats, then one decerr response
	always @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			wState  <= W_IDLE;
			awready <= 1'b1;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bid     <= {`AXI_ID_W{1'b0}};
			bresp   <= `AXI_RESP_DECERR;
			wAddr   <= `REG_ZERO;
		end
		else
		begin
			case (wState)
			W_IDLE:
				if (awvalid)
				begin
					awready <= 1'b0;
					wready  <= 1'b1;
					bid     <= awid;
					wAddr   <= awaddr;
					wState  <= W_DATA;
				end
			W_DATA:
				// data of one burst only; no interleave handling
				if (wvalid && wlast)
				begin
					wready <= 1'b0;
					bvalid <= 1'b1;
					wState <= W_RESP;
				end
			W_RESP:
				if (bready)
				begin
					bvalid  <= 1'b0;
					awready <= 1'b1;
					wState  <= W_IDLE;
				end
			default:
				wState <= W_IDLE;
			endcase
		end
	end
	// read channel: arlen+1 beats of zero data, each decerr, own fsm
	always @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			rState    <= R_IDLE;
			arready   <= 1'b1;
			rvalid    <= 1'b0;
			rlast     <= 1'b0;
			rid       <= {`AXI_ID_W{1'b0}};
			rdata     <= `AXI_DATA_ZERO;
			rresp     <= `AXI_RESP_DECERR;
			rAddr     <= `REG_ZERO;
			beatsLeft <= `AXI_ZERO_LEN;
		end
		else
		begin
			case (rState)
			R_IDLE:
				if (arvalid)
				begin
					arready   <= 1'b0;
					rid       <= arid;
					rAddr     <= araddr;
					rvalid    <= 1'b1;
					rlast     <= (arlen == `AXI_ZERO_LEN);
					beatsLeft <= arlen;
					rState    <= R_DATA;
				end
			R_DATA:
				if (rready)
				begin
					if (rlast)
					begin
						rvalid  <= 1'b0;
						rlast   <= 1'b0;
						arready <= 1'b1;
						rState  <= R_IDLE;
					end
					else
					begin
						beatsLeft <= beatsLeft - `AXI_ONE_LEN;
						rlast     <= (beatsLeft == `AXI_ONE_LEN);
					end
				end
			default:
				rState <= R_IDLE;
			endcase
		end
	end
	// per-channel logs; reading the address word frees the entry
	err_log_fifo uReadLog
	(
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.push     (rDone),
		.pushData ({rid, rAddr}),
		.pop      (rLogPop),
		.headData (rLogHead),
		.notEmpty (rLogValid),
		.full     (rLogFull)
	);
	err_log_fifo uWriteLog
	(
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.push     (wDone),
		.pushData ({bid, wAddr}),
		.pop      (wLogPop),
		.headData (wLogHead),
		.notEmpty (wLogValid),
		.full     (wLogFull)
	);
	// apb access phase completes when pready is high
	assign apbWrite  = psel & penable & pready & pwrite;
	assign apbRead   = psel & penable & pready & ~pwrite;
	assign rLogPop   = apbRead & (paddr == `CSR_RLOG_ADDR);
	assign wLogPop   = apbRead & (paddr == `CSR_WLOG_ADDR);
	// status: sets win over w1c; violation bits follow the logs
	always @*
	begin
		next_status = status;
		// violation bits drop only once nothing is left to report
		next_status[`ST_RD_INT] = rDone
		                          | (status[`ST_RD_INT] & rLogValid);
		next_status[`ST_WR_INT] = wDone
		                          | (status[`ST_WR_INT] & wLogValid);
		if (apbWrite && paddr == `CSR_STATUS)
		begin
			if (pwdata[`ST_RD_OVF])
				next_status[`ST_RD_OVF] = 1'b0;
			if (pwdata[`ST_WR_OVF])
				next_status[`ST_WR_OVF] = 1'b0;
		end
		if (rDone && rLogFull && !rLogPop)
			next_status[`ST_RD_OVF] = 1'b1;
		if (wDone && wLogFull && !wLogPop)
			next_status[`ST_WR_OVF] = 1'b1;
	end
	// read mux; unmapped addresses answer zero with pslverr
	always @*
	begin
		next_prdata = `REG_ZERO;
		next_slverr = 1'b0;
		case (paddr)
		`CSR_STATUS:
			next_prdata[`ST_W-1:0] = status;
		`CSR_MASK:
			next_prdata[`ST_W-1:0] = mask;
		`CSR_RLOG_INFO:
		begin
			next_prdata[`LOG_VALID_BIT] = rLogValid;
			next_prdata[`AXI_ID_W-1:0]  = rLogHead[`LOG_ENTRY_W-1:`AXI_ADDR_W];
		end
		`CSR_RLOG_ADDR:
			next_prdata = rLogHead[`AXI_ADDR_W-1:0];
		`CSR_WLOG_INFO:
		begin
			next_prdata[`LOG_VALID_BIT] = wLogValid;
			next_prdata[`AXI_ID_W-1:0]  = wLogHead[`LOG_ENTRY_W-1:`AXI_ADDR_W];
		end
		`CSR_WLOG_ADDR:
			next_prdata = wLogHead[`AXI_ADDR_W-1:0];
		default:
			next_slverr = 1'b1;
		endcase
	end
	// apb slave: no wait state; read data is registered in the setup cycle so it comes from a flop
	always @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `REG_ZERO;
			mask    <= `ST_ZERO;
			status  <= `ST_ZERO;
			irq     <= 1'b0;
		end
		else
		begin
			pready <= psel & ~penable & ~pready;
			if (psel && !penable && !pready)
			begin
				prdata  <= pwrite ? `REG_ZERO : next_prdata;
				pslverr <= next_slverr;
			end
			else if (!psel)
			begin
				prdata  <= `REG_ZERO;
				pslverr <= 1'b0;
			end
			if (apbWrite && paddr == `CSR_MASK)
				mask <= pwdata[`ST_W-1:0];
			status <= next_status;
			// level interrupt from unmasked sticky bits
			irq <= |(next_status & mask);
		end
	end
endmodule // axi_default_error_slave

// [src/err_log_fifo.v]
// violation log fifo with flip-flop storage
`timescale 1ns/100ps
`include "err_slave_defs.vh"

module err_log_fifo
(
	input  wire                    sys_clk,
	input  wire                    rst_b,
	input  wire                    push,
	input  wire [`LOG_ENTRY_W-1:0] pushData,
	input  wire                    pop,
	output wire [`LOG_ENTRY_W-1:0] headData,
	output wire                    notEmpty,
	output wire                    full
);

	reg  [`LOG_PTR_W-1:0]   wrPtr;
	reg  [`LOG_PTR_W-1:0]   rdPtr;
	reg  [`LOG_CNT_W-1:0]   count;
	wire [`LOG_ENTRY_W-1:0] slot [0:`LOG_FULL_CNT-1];
	wire                    doPush;
	wire                    doPop;

	// a push into a full log is dropped unless a pop frees a slot;
	// dropping it silently would lose an entry with no overflow flag
	assign full     = (count == `LOG_FULL_CNT);
	assign notEmpty = (count != `LOG_CNT_ZERO);
	assign doPush   = push & (~full | pop);
	assign doPop    = pop & notEmpty;
	assign headData = slot[rdPtr];

	// one storage word per entry
	genvar i;
	generate
		for (i = 0; i < `LOG_FULL_CNT; i = i + 1)
		begin : gEntry
			localparam integer          SLOT = i;
			localparam [`LOG_PTR_W-1:0] IDX  = SLOT[`LOG_PTR_W-1:0];
			reg [`LOG_ENTRY_W-1:0] entry;
			always @(posedge sys_clk)
			begin
				if (!rst_b)
					entry <= {`LOG_ENTRY_W{1'b0}};
				else if (doPush && wrPtr == IDX)
					entry <= pushData;
			end
			assign slot[i] = entry;
		end
	endgenerate

	// pointers and fill count
	always @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			wrPtr <= `LOG_PTR_ZERO;
			rdPtr <= `LOG_PTR_ZERO;
			count <= `LOG_CNT_ZERO;
		end
		else
		begin
			if (doPush)
				wrPtr <= (wrPtr == `LOG_LAST_PTR) ? `LOG_PTR_ZERO
				         : wrPtr + `LOG_PTR_ONE;
			if (doPop)
				rdPtr <= (rdPtr == `LOG_LAST_PTR) ? `LOG_PTR_ZERO
				         : rdPtr + `LOG_PTR_ONE;
			if (doPush && !doPop)
				count <= count + `LOG_CNT_ONE;
			else if (doPop && !doPush)
				count <= count - `LOG_CNT_ONE;
		end
	end

endmodule // err_log_fifo

// [test/axi_default_error_slave_asserts.sv]
// concurrent checks on the error slave ports
`timescale 1ns/100ps
`include "err_slave_defs.vh"

module err_slave_checker
(
	input logic       sys_clk,
	input logic       rst_b,
	input logic       awvalid,
	input logic       awready,
	input logic       wvalid,
	input logic       wready,
	input logic       wlast,
	input logic       bvalid,
	input logic       bready,
	input logic [1:0] bresp,
	input logic       arvalid,
	input logic       arready,
	input logic       rvalid,
	input logic       rready,
	input logic       rlast,
	input logic [1:0] rresp
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	// handshake steps of one transfer
	sequence aw_take; awvalid && awready; endsequence
	sequence w_end; wvalid && wready && wlast; endsequence
	sequence b_take; bvalid && bready; endsequence
	sequence ar_take; arvalid && arready; endsequence
	sequence r_end; rvalid && rready && rlast; endsequence

	a_write_decerr: assert property (
		bvalid |-> bresp == `AXI_RESP_DECERR) else $error("bad bresp");
	a_read_decerr: assert property (
		rvalid |-> rresp == `AXI_RESP_DECERR) else $error("bad rresp");
	a_single_write: assert property (
		aw_take |=> !awready && wready) else $error("aw not closed");
	a_write_refused: assert property (
		bvalid |-> !awready) else $error("aw open during b");
	a_single_read: assert property (
		ar_take |=> !arready && rvalid) else $error("ar not closed");
	a_resp_after_last: assert property (
		w_end |=> bvalid) else $error("no b after wlast");
	a_bresp_holds: assert property (
		bvalid && !bready |=> bvalid) else $error("b dropped");
	a_aw_reopens: assert property (
		b_take |=> awready && !bvalid) else $error("aw not reopened");
	a_ar_reopens: assert property (
		r_end |=> arready && !rvalid) else $error("ar not reopened");
	a_beat_holds: assert property (
		rvalid && !rready |=> rvalid && $stable(rlast))
		else $error("r beat dropped");
endmodule // err_slave_checker

bind axi_default_error_slave err_slave_checker chk_u (.*);

// [test/axi_default_error_slave_test.sv]
// self-checking bench for the axi default error slave
`timescale 1ns/100ps
`include "err_slave_defs.vh"

module axi_default_error_slave_test;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [3:0]  awid, arid, bid, rid;
	logic [31:0] awaddr, araddr, wdata, rdata, prdata, q;
	logic [7:0]  awlen, arlen;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wlast, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rlast, rvalid, rready, irq, pready;
	logic        pslverr, err;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	// ignored by the slave, so tied
	logic [2:0]  awsize = 3'h2, arsize = 3'h2;
	logic [1:0]  awburst = 2'h1, arburst = 2'h1;
	logic [3:0]  wstrb = 4'hf;
	logic [5:0]  rsp;
	int          mismatches = 0;
	int          samples_checked = 0;
	int          n;
	int          bad;

	axi_default_error_slave dut_u (.*);
	axi_master_model master_u (.*);

	always #20 sys_clk = ~sys_clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// setup then access until pready; one idle edge after
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (!pready);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		apb(1'b0, `CSR_STATUS, 32'h0);
		chk(q, 32'h0);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `CSR_MASK, 32'h0000_000f);
		apb(1'b0, `CSR_MASK, 32'h0);
		chk(q, 32'h0000_000f);
		// read and write at once, slow read side
		fork
			master_u.wr(4'h1, 8'h02, rsp);
			master_u.rd(4'h2, 8'h03, 2, n, bad);
		join
		chk({26'h0, rsp}, 32'h0000_0007);
		chk(n, 32'h0000_0004);
		chk(bad, 32'h0);
		apb(1'b0, `CSR_STATUS, 32'h0);
		chk(q, 32'h0000_0003);
		chk({31'h0, irq}, 32'h0000_0001);
		apb(1'b0, `CSR_RLOG_INFO, 32'h0);
		chk(q, 32'h8000_0002);
		apb(1'b0, `CSR_RLOG_ADDR, 32'h0);
		chk(q, 32'h0000_0202);
		apb(1'b0, `CSR_STATUS, 32'h0);
		chk(q, 32'h0000_0002);
		// one more push than each log holds
		for (int i = 1; i < 6; i++)
		begin
			if (i > 1)
			begin
				master_u.wr(i[3:0], 8'h00, rsp);
				chk({26'h0, rsp}, {26'h0, i[3:0], `AXI_RESP_DECERR});
			end
			master_u.rd(i[3:0], 8'h00, 0, n, bad);
			chk(n, 32'h0000_0001);
			chk(bad, 32'h0);
		end
		apb(1'b0, `CSR_STATUS, 32'h0);
		chk(q, 32'h0000_000f);
		apb(1'b1, `CSR_STATUS, 32'h0000_000f);
		apb(1'b0, `CSR_STATUS, 32'h0);
		chk(q, 32'h0000_0003);
		apb(1'b1, `CSR_MASK, 32'h0);
		// irq is launched at the edge the task returns on
		@(posedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, `CSR_MASK, 32'h0000_000f);
		for (int i = 1; i < 5; i++)
		begin
			apb(1'b0, `CSR_WLOG_INFO, 32'h0);
			chk(q, 32'h8000_0000 | i);
			apb(1'b0, `CSR_WLOG_ADDR, 32'h0);
			chk(q, 32'h0000_0100 | i);
			apb(1'b0, `CSR_RLOG_ADDR, 32'h0);
			chk(q, 32'h0000_0200 | i);
		end
		apb(1'b0, `CSR_RLOG_INFO, 32'h0);
		chk({31'h0, q[`LOG_VALID_BIT]}, 32'h0);
		apb(1'b0, `CSR_STATUS, 32'h0);
		chk(q, 32'h0);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, 8'h3c, 32'h0);
		chk({q[30:0], err}, 32'h0000_0001);
		report_and_stop;
	end

	// hang guard, far beyond the hundred or so cycles used
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		mismatches++;
		report_and_stop;
	end
endmodule // axi_default_error_slave_test

// [test/axi_master_model.sv]
// behavioural axi master issuing undecoded accesses
`timescale 1ns/100ps
`include "err_slave_defs.vh"

module axi_master_model
(
	input  logic        sys_clk,
	output logic [3:0]  awid,
	output logic [31:0] awaddr,
	output logic [7:0]  awlen,
	output logic        awvalid,
	input  logic        awready,
	output logic [31:0] wdata,
	output logic        wlast,
	output logic        wvalid,
	input  logic        wready,
	input  logic [3:0]  bid,
	input  logic [1:0]  bresp,
	input  logic        bvalid,
	output logic        bready,
	output logic [3:0]  arid,
	output logic [31:0] araddr,
	output logic [7:0]  arlen,
	output logic        arvalid,
	input  logic        arready,
	input  logic [3:0]  rid,
	input  logic [31:0] rdata,
	input  logic [1:0]  rresp,
	input  logic        rlast,
	input  logic        rvalid,
	output logic        rready
);
	// idle bus at time zero
	initial
	begin
		{awvalid, wvalid, wlast, bready, arvalid, rready} = 6'h00;
		{awid, arid, awlen, arlen, awaddr, araddr, wdata} = 120'h0;
	end

	// whole bursts one at a time, so data never interleave
	task automatic wr(input logic [3:0] id, input logic [7:0] len,
		output logic [5:0] rsp);
		awid <= id;
		awaddr <= 32'h0000_0100 | id;
		awlen <= len;
		awvalid <= 1'b1;
		do @(posedge sys_clk); while (!awready);
		awvalid <= 1'b0;
		awaddr <= ~awaddr;
		for (int i = 0; i <= len; i++)
		begin
			wdata <= ~wdata;
			wlast <= (i == len);
			wvalid <= 1'b1;
			do @(posedge sys_clk); while (!wready);
		end
		wvalid <= 1'b0;
		wlast <= 1'b0;
		wdata <= ~wdata;
		bready <= 1'b1;
		do @(posedge sys_clk); while (!bvalid);
		rsp = {bid, bresp};
		bready <= 1'b0;
	endtask

	// read burst; stall delays rready so beats must wait
	task automatic rd(input logic [3:0] id, input logic [7:0] len,
		input int stall, output int n, output int bad);
		arid <= id;
		araddr <= 32'h0000_0200 | id;
		arlen <= len;
		arvalid <= 1'b1;
		do @(posedge sys_clk); while (!arready);
		arvalid <= 1'b0;
		araddr <= ~araddr;
		n = 0;
		bad = 0;
		repeat (stall) @(posedge sys_clk);
		rready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			n += rvalid;
			bad += rvalid && (rid !== id || rresp !== `AXI_RESP_DECERR
				|| rdata !== `AXI_DATA_ZERO || rlast !== (n == len + 1));
		end
		while (!(rvalid && rlast));
		rready <= 1'b0;
	endtask
endmodule // axi_master_model
